/* File: core/nvc_cfg.svh */
// Constants of the NVM command controller
//
// Contract
// R1 - Erase-write erases then programs, buffer kept
// R2 - Flash erase-write stalls CPU, EEPROM does not
// R3 - Buffer cleared after erase-write ends
// R4 - Buffer clear sets ones, stalls seven cycles
// R5 - Chip erase ignores guards, spares EEPROM optionally
// R6 - EEPROM erase sets ones, stalls CPU
// R7 - Fuse write only from debug port
// R8 - Programmer loads address, data, command, resets
// R9 - Post power-on lockout rejects writes, busy high
// R10 - Issuer waits for both busy flags low
// R11 - Lockout skipped by fuse or pin function
// R12 - Reset aborts a running write
// R13 - Request while enabled and flag set
// R14 - Sleep held off until write completes
// R15 - Ready event wakes from Idle only
// R16 - Wake-up clears page buffer to ones
// R17 - Protected writes need key within four instructions
// R18 - Three-bit command code decode
// R19 - Boot lock blanks boot reads, armed on exit
// R20 - App write guard set-only, reset clears
// R21 - Fault flag marks failed last operation
// R22 - Busy flags follow active memory
// R23 - Ready flag set while EEPROM idle, W1C; code sets it only once a write or erase command has been accepted since reset
`ifndef NVC_CFG_SVH
`define NVC_CFG_SVH

// ==========================================================
// Register offsets
`define NVC_OFF_CMD      4'h0
`define NVC_OFF_LOCK     4'h1
`define NVC_OFF_STATUS   4'h2
`define NVC_OFF_INTEN    4'h3
`define NVC_OFF_INTFLAG  4'h4
`define NVC_OFF_DATA_LO  4'h6
`define NVC_OFF_DATA_HI  4'h7
`define NVC_OFF_ADDR_LO  4'h8
`define NVC_OFF_ADDR_HI  4'h9

// ==========================================================
// Field positions
`define NVC_BIT_APPGUARD 0
`define NVC_BIT_BOOT_REGION_LOCK 1
`define NVC_BIT_FLASH_BUSY_FLAG    0
`define NVC_BIT_EEPROM_BUSY_FLAG   1
`define NVC_BIT_FAULT    2
`define NVC_BIT_EEPROM_READY_EVENT  0

// ==========================================================
// Command codes
`define NVC_CMD_NONE     3'h0
`define NVC_CMD_WRITE    3'h1
`define NVC_CMD_ERASE    3'h2
`define NVC_CMD_ERWR     3'h3
`define NVC_CMD_PBCLR    3'h4
`define NVC_CMD_CHIP     3'h5
`define NVC_CMD_EEERASE  3'h6
`define NVC_CMD_FUSE     3'h7

// ==========================================================
// Reset values, counts and address decode
`define NVC_RST_BYTE     8'h00
`define NVC_RST_WORD     16'h0000
`define NVC_PBC_CYCLES   3'h7
`define NVC_KEY_WINDOW   3'h4
`define NVC_FLASH_BASE   16'h8000
`define NVC_LOCKOUT_DEF  1024

`endif

/* File: core/nvc_pkg.sv */
// Types of the NVM command controller
package nvc_pkg;

    typedef enum logic [2:0] {
        ST_INIT,
        ST_LOCKOUT,
        ST_IDLE,
        ST_ARRAY,
        ST_ERWR_ERASE,
        ST_PBCLR
    } nvc_fsm_t;

    typedef enum logic [2:0] {
        OP_WRITE,
        OP_ERASE,
        OP_CHIP,
        OP_EEERASE,
        OP_FUSE
    } nvc_op_kind_t;

    // Request to the memory array
    typedef struct packed {
        logic         start;
        nvc_op_kind_t kind;
        logic         eeprom;
        logic         keepEeprom;
        logic [15:0]  addr;
        logic [15:0]  data;
    } nvc_array_req_t;

    // Fuse straps, same clock domain
    typedef struct packed {
        logic keepEeprom;
        logic timeoutOff;
        logic resetPinProg;
    } nvc_fuse_t;

    typedef struct packed {
        nvc_fsm_t       fsm;
        logic [2:0]     cmd;
        logic           bootArm;
        logic           bootOn;
        logic           appGuard;
        logic           fault;
        logic           intEn;
        logic           eeFlag;
        logic           cmdSeen;
        logic [15:0]    data;
        logic [15:0]    addr;
        logic [2:0]     spmCnt;
        logic [2:0]     ioCnt;
        logic [15:0]    lockCnt;
        logic [2:0]     pbcCnt;
        logic           opEe;
        logic           opFlash;
        logic           pbClear;
        nvc_array_req_t req;
        logic [7:0]     rdData;
    } nvc_state_t;

endpackage : nvc_pkg

/* File: core/nvc_ctrl.sv */
// NVM command controller: command sequencing, protection, status
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "nvc_cfg.svh"

module nvc_ctrl
    import nvc_pkg::*;
#(
    parameter int unsigned LOCKOUT_CYCLES = `NVC_LOCKOUT_DEF
) (
    input  wire logic           clk,
    input  wire logic           rstn,
    input  wire logic           clkEn,
    input  wire logic [3:0]     regAddr,
    input  wire logic [7:0]     regWrData,
    input  wire logic           regWr,
    input  wire logic           regRd,
    output logic      [7:0]     regRdData,
    input  wire logic           fromDebugPort,
    input  wire logic           keySelfprog,
    input  wire logic           keyIoReg,
    input  wire logic           instrDone,
    input  wire logic           execInBoot,
    input  wire logic           powerOnReset,
    input  wire nvc_fuse_t      fuse,
    input  wire logic           targetBoot,
    input  wire logic           targetAppCode,
    input  wire logic           sectionMismatch,
    output nvc_array_req_t      arrayReq,
    input  wire logic           arrayDone,
    output logic                arrayAbort,
    output logic                pageBufClear,
    output logic                cpuStall,
    output logic                bootBlank,
    output logic                irq,
    input  wire logic           sleepReq,
    input  wire logic           sleepIdle,
    input  wire logic           wakeUp,
    output logic                wakeReq,
    output logic                ctrlSleep,
    output logic                clockHold
);

    // ==========================================================
    // State
    nvc_state_t st;
    nvc_state_t next_st;

    localparam logic [15:0] LOCK_LAST = 16'(LOCKOUT_CYCLES - 1);

    logic       flashBusy;
    logic       eeprom_busy_flag;
    logic       wrCmd;
    logic       wrLock;
    logic       busyAny;
    logic [2:0] code;

    function automatic logic isEeprom(input logic [15:0] a);
        isEeprom = (a < `NVC_FLASH_BASE);
    endfunction : isEeprom

    function automatic logic [2:0] countDown(input logic [2:0] c,
                                             input logic       step);
        countDown = (step && c != 3'h0) ? c - 3'h1 : c;
    endfunction : countDown

    // ==========================================================
    // Status decode
    always_comb begin
        busyAny   = (st.fsm != ST_IDLE);
        // R9 R22
        flashBusy = (st.fsm == ST_INIT) || (st.fsm == ST_LOCKOUT)
                    || st.opFlash;
        eeprom_busy_flag    = (st.fsm == ST_INIT) || (st.fsm == ST_LOCKOUT)
                    || st.opEe;
        code      = regWrData[2:0];
        // Debug port writes are not subject to the key window
        wrCmd  = regWr && regAddr == `NVC_OFF_CMD
                 && (fromDebugPort || st.spmCnt != 3'h0); // R17
        wrLock = regWr && regAddr == `NVC_OFF_LOCK
                 && (fromDebugPort || st.ioCnt != 3'h0);  // R17
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_st             = st;
        next_st.req.start   = 1'b0;
        next_st.pbClear     = 1'b0;

        // Key windows count retired instructions
        next_st.spmCnt = keySelfprog ? `NVC_KEY_WINDOW
                         : countDown(st.spmCnt, instrDone); // R17
        next_st.ioCnt  = keyIoReg ? `NVC_KEY_WINDOW
                         : countDown(st.ioCnt, instrDone);  // R17

        // Boot lock goes live once code leaves the boot region
        if (st.bootArm && !execInBoot) begin
            next_st.bootOn = 1'b1; // R19
        end

        // Plain registers
        if (regWr) begin
            case (regAddr)
                `NVC_OFF_INTEN: begin
                    next_st.intEn = regWrData[`NVC_BIT_EEPROM_READY_EVENT];
                end
                `NVC_OFF_DATA_LO: begin
                    next_st.data[7:0] = regWrData;
                end
                `NVC_OFF_DATA_HI: begin
                    next_st.data[15:8] = regWrData;
                end
                `NVC_OFF_ADDR_LO: begin
                    next_st.addr[7:0] = regWrData;
                end
                `NVC_OFF_ADDR_HI: begin
                    next_st.addr[15:8] = regWrData;
                end
                default: begin
                end
            endcase
        end

        // Lock bits are set-only; only reset clears them
        if (wrLock) begin
            if (regWrData[`NVC_BIT_APPGUARD]) begin
                next_st.appGuard = 1'b1; // R20
            end
            if (regWrData[`NVC_BIT_BOOT_REGION_LOCK] && execInBoot) begin
                next_st.bootArm = 1'b1; // R19
            end
        end

        // Ready flag: W1C, but the idle level wins over the clear
        if (regWr && regAddr == `NVC_OFF_INTFLAG
            && regWrData[`NVC_BIT_EEPROM_READY_EVENT]) begin
            next_st.eeFlag = 1'b0; // R23
        end
        if (st.cmdSeen && !eeprom_busy_flag) begin
            next_st.eeFlag = 1'b1; // R23
        end

        case (st.fsm)
            ST_INIT: begin
                next_st.pbClear = 1'b1;
                next_st.lockCnt = `NVC_RST_WORD;
                // Lockout only after power-on, unless a fuse skips it
                if (powerOnReset && fuse.timeoutOff
                    && !fuse.resetPinProg) begin
                    next_st.fsm = ST_LOCKOUT; // R11
                end else begin
                    next_st.fsm = ST_IDLE; // R11
                end
            end
            ST_LOCKOUT: begin
                if (wrCmd && code != `NVC_CMD_NONE) begin
                    next_st.fault = 1'b1; // R9
                end
                if (st.lockCnt >= LOCK_LAST) begin
                    next_st.fsm = ST_IDLE;
                end else begin
                    next_st.lockCnt = st.lockCnt + 16'h0001; // R9
                end
            end
            ST_IDLE: begin
                if (wrCmd && !(code == `NVC_CMD_FUSE
                               && !fromDebugPort)) begin // R7
                    next_st.cmd          = code;
                    next_st.fault        = 1'b0;
                    next_st.req.eeprom   = isEeprom(st.addr); // R18
                    next_st.req.addr     = st.addr;
                    next_st.req.data     = st.data; // R8
                    next_st.req.keepEeprom = fuse.keepEeprom;
                    case (code) // R18
                        `NVC_CMD_WRITE, `NVC_CMD_ERASE,
                        `NVC_CMD_ERWR: begin
                            if (!isEeprom(st.addr) && (targetBoot
                                || (targetAppCode && st.appGuard)
                                || (code != `NVC_CMD_ERASE
                                    && sectionMismatch))) begin
                                next_st.fault = 1'b1; // R20 R21
                            end else begin
                                next_st.cmdSeen   = 1'b1;
                                next_st.req.start = 1'b1;
                                next_st.req.kind  =
                                    (code == `NVC_CMD_WRITE)
                                    ? OP_WRITE : OP_ERASE; // R1
                                next_st.opEe    = isEeprom(st.addr);
                                next_st.opFlash = !isEeprom(st.addr);
                                next_st.fsm = (code == `NVC_CMD_ERWR)
                                    ? ST_ERWR_ERASE : ST_ARRAY; // R1
                            end
                        end
                        `NVC_CMD_PBCLR: begin
                            next_st.pbClear = 1'b1; // R4
                            next_st.pbcCnt  = `NVC_PBC_CYCLES;
                            next_st.fsm     = ST_PBCLR;
                        end
                        `NVC_CMD_CHIP: begin
                            // Guards are not consulted
                            next_st.cmdSeen   = 1'b1;
                            next_st.req.start = 1'b1;
                            next_st.req.kind  = OP_CHIP; // R5
                            next_st.opFlash   = 1'b1;
                            next_st.opEe      = !fuse.keepEeprom; // R5
                            next_st.fsm       = ST_ARRAY;
                        end
                        `NVC_CMD_EEERASE: begin
                            next_st.cmdSeen   = 1'b1;
                            next_st.req.start = 1'b1;
                            next_st.req.kind  = OP_EEERASE; // R6
                            next_st.opEe      = 1'b1;
                            next_st.fsm       = ST_ARRAY;
                        end
                        `NVC_CMD_FUSE: begin
                            next_st.req.start = 1'b1;
                            next_st.req.kind  = OP_FUSE; // R7
                            next_st.opFlash   = 1'b1;
                            next_st.fsm       = ST_ARRAY;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_ERWR_ERASE: begin
                // Buffer kept across the erase so the write sees it
                if (arrayDone) begin
                    next_st.req.start = 1'b1;
                    next_st.req.kind  = OP_WRITE; // R1
                    next_st.fsm       = ST_ARRAY;
                end
            end
            ST_ARRAY: begin
                if (arrayDone) begin
                    next_st.pbClear = 1'b1; // R3
                    next_st.opEe    = 1'b0;
                    next_st.opFlash = 1'b0;
                    next_st.fsm     = ST_IDLE;
                end
            end
            ST_PBCLR: begin
                next_st.pbcCnt = st.pbcCnt - 3'h1;
                if (st.pbcCnt == 3'h1) begin
                    next_st.fsm = ST_IDLE; // R4
                end
            end
            default: begin
                next_st.fsm = ST_IDLE;
            end
        endcase

        if (wakeUp) begin
            next_st.pbClear = 1'b1; // R16
        end

        // Read data stands in the cycle after the strobe only
        next_st.rdData = `NVC_RST_BYTE;
        if (regRd) begin
            case (regAddr)
                `NVC_OFF_CMD: begin
                    next_st.rdData = {5'h00, st.cmd};
                end
                `NVC_OFF_LOCK: begin
                    next_st.rdData = {6'h00, st.bootArm, st.appGuard};
                end
                `NVC_OFF_STATUS: begin
                    next_st.rdData = {5'h00, st.fault, eeprom_busy_flag,
                                      flashBusy}; // R21 R22
                end
                `NVC_OFF_INTEN: begin
                    next_st.rdData = {7'h00, st.intEn};
                end
                `NVC_OFF_INTFLAG: begin
                    next_st.rdData = {7'h00, st.eeFlag};
                end
                `NVC_OFF_DATA_LO: begin
                    next_st.rdData = st.data[7:0];
                end
                `NVC_OFF_DATA_HI: begin
                    next_st.rdData = st.data[15:8];
                end
                `NVC_OFF_ADDR_LO: begin
                    next_st.rdData = st.addr[7:0];
                end
                `NVC_OFF_ADDR_HI: begin
                    next_st.rdData = st.addr[15:8];
                end
                default: begin
                    next_st.rdData = `NVC_RST_BYTE;
                end
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st        <= '0;
            st.fsm    <= ST_INIT;
            st.req.kind <= OP_WRITE;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    always_comb begin
        regRdData    = st.rdData;
        arrayReq     = st.req;
        // Array sees the reset directly; a held write cannot finish
        arrayAbort   = !rstn; // R12
        pageBufClear = st.pbClear; // R4 R16
        // EEPROM page work runs in the background
        cpuStall     = st.opFlash || st.fsm == ST_PBCLR
                       || (st.fsm != ST_IDLE && st.opEe
                           && st.req.kind != OP_WRITE
                           && st.req.kind != OP_ERASE); // R2 R6
        bootBlank    = st.bootOn; // R19
        irq          = st.intEn && st.eeFlag; // R13
        wakeReq      = irq && sleepIdle; // R15
        ctrlSleep    = sleepReq && !busyAny; // R14
        clockHold    = sleepReq && (st.opEe || st.opFlash); // R14
    end

endmodule : nvc_ctrl
`default_nettype wire

/* File: tb/nvc_ctrl_properties.sv */
// Port-level checker of the NVM command controller
`timescale 1ns/1ps
`default_nettype none

module nvc_ctrl_properties
    import nvc_pkg::*;
(
    input wire logic           clk,
    input wire logic           rstn,
    input wire logic           clkEn,
    input wire logic [3:0]     regAddr,
    input wire logic [7:0]     regWrData,
    input wire logic           regWr,
    input wire logic           fromDebugPort,
    input wire nvc_array_req_t arrayReq,
    input wire logic           arrayDone,
    input wire logic           arrayAbort,
    input wire logic           pageBufClear,
    input wire logic           irq,
    input wire logic           sleepReq,
    input wire logic           sleepIdle,
    input wire logic           wakeUp,
    input wire logic           wakeReq,
    input wire logic           ctrlSleep,
    input wire logic           clockHold
);
    // ========
    // Assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_abort_by_reset: assert property (
        disable iff (1'b0) arrayAbort == !rstn)
        else $error("abort line does not follow reset");
    a_start_one_cycle: assert property (
        arrayReq.start && clkEn |=> !arrayReq.start)
        else $error("array start longer than one cycle");
    a_cpu_fuse_refused: assert property (
        regWr && clkEn && regAddr == 4'h0 && regWrData[2:0] == 3'h7
        && !fromDebugPort && !arrayDone |=> !arrayReq.start)
        else $error("fuse write started from the CPU");
    a_wake_idle_only: assert property (
        wakeReq == (irq && sleepIdle))
        else $error("wake request outside idle sleep");
    a_hold_not_sleep: assert property (
        clockHold |-> sleepReq && !ctrlSleep)
        else $error("controller sleeps while holding the clock");
    a_hold_until_done: assert property (
        clockHold && !arrayDone |=> clockHold || !sleepReq)
        else $error("clock released before the write ended");
    a_awake_no_sleep: assert property (
        !sleepReq |-> !ctrlSleep && !clockHold)
        else $error("sleep signals without a sleep request");
    a_irq_held_set: assert property (
        irq && !(regWr && clkEn && (regAddr == 4'h3 || regAddr == 4'h4))
        |=> irq)
        else $error("interrupt request dropped without a clear");
    a_wake_buf_clear: assert property (
        wakeUp && clkEn |=> pageBufClear)
        else $error("page buffer not cleared on wake-up");
endmodule : nvc_ctrl_properties

bind nvc_ctrl nvc_ctrl_properties chk_u (.clk, .rstn, .clkEn, .regAddr,
    .regWrData, .regWr, .fromDebugPort, .arrayReq, .arrayDone, .arrayAbort,
    .pageBufClear, .irq, .sleepReq, .sleepIdle, .wakeUp, .wakeReq,
    .ctrlSleep, .clockHold);

`default_nettype wire

/* File: tb/nvc_array_model.sv */
// Memory array stand-in: answers each request after a short or long delay
`timescale 1ns/1ps
`default_nettype none

module nvc_array_model
    import nvc_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rstn,
    input  wire nvc_array_req_t req,
    input  wire logic           slow,
    output logic                done
);
    int cnt = 0;

    initial done = 1'b0;

    // ========
    // Long delay keeps an operation open across register traffic
    always @(posedge clk) begin
        done <= 1'b0;
        if (!rstn)
            cnt <= 0;
        else if (req.start)
            cnt <= slow ? 20 : 3;
        else if (cnt == 1) begin
            cnt  <= 0;
            done <= 1'b1;
        end else if (cnt > 1)
            cnt <= cnt - 1;
    end
endmodule : nvc_array_model

`default_nettype wire

/* File: tb/nvc_ctrl_tb_top.sv */
// Self-checking bench of the NVM command controller
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin \
    nChecks++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("ERROR %0t: got %0h expected %0h", $time, g, e); \
    end \
end

module nvc_ctrl_tb_top
    import nvc_pkg::*;
;
    logic           clk = 1'b0;
    logic           rstn = 1'b0;
    logic           regWr = 1'b0;
    logic           regRd = 1'b0;
    logic [3:0]     regAddr = 4'h0;
    logic [7:0]     regWrData = 8'h00;
    logic           fromDebugPort = 1'b0;
    logic           keySelfprog = 1'b0;
    logic           keyIoReg = 1'b0;
    logic           instrDone = 1'b0;
    logic           powerOnReset = 1'b1;
    nvc_fuse_t      fuse = 3'b010;
    logic           targetAppCode = 1'b0;
    logic           execInBoot = 1'b0;
    logic           sectionMismatch = 1'b0;
    logic           bootBlank;
    logic           sleepReq = 1'b0;
    logic           sleepIdle = 1'b0;
    logic           wakeUp = 1'b0;
    logic           slow = 1'b0;
    logic [7:0]     regRdData;
    nvc_array_req_t arrayReq;
    nvc_array_req_t r;
    logic           arrayDone;
    logic           arrayAbort;
    logic           pageBufClear;
    logic           cpuStall;
    logic           irq;
    logic           wakeReq;
    logic           ctrlSleep;
    logic           clockHold;
    logic           seen;
    logic           st;
    logic [7:0]     got;
    int             miscompares = 0;
    int             nChecks = 0;
    int             stalls = 0;

    // Short lockout keeps the run brief
    nvc_ctrl #(.LOCKOUT_CYCLES(8)) dut_u (.*, .clkEn(1'b1),
        .targetBoot(1'b0));
    nvc_array_model mdl_u (.clk, .rstn, .req(arrayReq), .slow,
        .done(arrayDone));

    always #20 clk = ~clk;

    always @(posedge clk)
        if (cpuStall === 1'b1)
            stalls <= stalls + 1;

    // ========
    // Bus and sequence tasks
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        keySelfprog <= 1'b0;
        keyIoReg <= 1'b0;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask : rd

    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        rd(a, got);
        `CHK(got, e)
    endtask : rc

    task automatic waitIdle;
        int i;
        got = 8'h03;
        for (i = 0; i < 60 && got[1:0] !== 2'b00; i++)
            rd(4'h2, got);
        `CHK(got[1:0], 2'b00)
    endtask : waitIdle

    task automatic waitFor(input logic buffer_clear_cmd, input int n);
        int i;
        seen = 1'b0;
        for (i = 0; i < n && !seen; i++) begin
            #1;
            seen = buffer_clear_cmd ? pageBufClear : arrayReq.start;
            r = arrayReq;
            st = cpuStall;
            if (!seen)
                @(posedge clk);
        end
    endtask : waitFor

    task automatic cmd(input logic [2:0] c, input int ni);
        waitIdle();
        @(posedge clk);
        keySelfprog <= 1'b1;
        repeat (ni) begin
            @(posedge clk);
            keySelfprog <= 1'b0;
            instrDone <= 1'b1;
            @(posedge clk);
            instrDone <= 1'b0;
        end
        wr(4'h0, {5'h00, c});
        waitFor(1'b0, 8);
    endtask : cmd

    task automatic lock(input logic [7:0] d);
        @(posedge clk);
        keyIoReg <= 1'b1;
        wr(4'h1, d);
    endtask : lock

    task automatic rst(input nvc_fuse_t f);
        @(posedge clk);
        rstn <= 1'b0;
        fuse <= f;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
    endtask : rst

    task automatic fin(input string s);
        $display("test %s done", s);
    endtask : fin

    task automatic printVerdict;
        $display("checks %0d, mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : printVerdict

    // Whole run is near 400 cycles; ten thousand means a hang
    initial begin
        #400000;
        miscompares++;
        printVerdict();
    end

    // ========
    // Tests
    initial begin
        rst(3'b010);
        rc(4'h2, 8'h03);
        @(posedge clk);
        keySelfprog <= 1'b1;
        wr(4'h0, 8'h01);
        waitFor(1'b0, 4);
        `CHK(seen, 1'b0)
        repeat (12) @(posedge clk);
        rc(4'h2, 8'h04);
        rc(4'h0, 8'h00);
        rc(4'h5, 8'h00);
        fin("lockout");
        rst(3'b111);
        rc(4'h2, 8'h00);
        wr(4'h9, 8'h80);
        slow <= 1'b1;
        cmd(3'h3, 0);
        `CHK(r.kind, OP_ERASE)
        `CHK(st, 1'b1)
        rc(4'h2, 8'h01);
        waitFor(1'b0, 60);
        `CHK(r.kind, OP_WRITE)
        waitFor(1'b1, 60);
        `CHK(seen, 1'b1)
        `CHK(st, 1'b0)
        wr(4'h9, 8'h00);
        cmd(3'h3, 0);
        `CHK(st, 1'b0)
        rc(4'h2, 8'h02);
        waitFor(1'b0, 60);
        `CHK(r.kind, OP_WRITE)
        fin("erase-write");
        slow <= 1'b0;
        waitIdle();
        stalls = 0;
        cmd(3'h4, 0);
        `CHK(seen, 1'b0)
        repeat (8) @(posedge clk);
        `CHK(stalls, 7)
        cmd(3'h6, 0);
        `CHK(r.kind, OP_EEERASE)
        `CHK(st, 1'b1)
        cmd(3'h7, 0);
        `CHK(seen, 1'b0)
        rc(4'h0, 8'h06);
        wr(4'h8, 8'h34);
        wr(4'h9, 8'h12);
        wr(4'h6, 8'hcd);
        wr(4'h7, 8'hab);
        fromDebugPort <= 1'b1;
        cmd(3'h7, 0);
        fromDebugPort <= 1'b0;
        `CHK(r.kind, OP_FUSE)
        `CHK(r.addr, 16'h1234)
        `CHK(r.data, 16'habcd)
        rst(3'b111);
        fin("commands");
        cmd(3'h1, 5);
        `CHK(seen, 1'b0)
        cmd(3'h1, 3);
        `CHK(seen, 1'b1)
        wr(4'h1, 8'h01);
        rc(4'h1, 8'h00);
        lock(8'h01);
        lock(8'h00);
        rc(4'h1, 8'h01);
        targetAppCode <= 1'b1;
        wr(4'h9, 8'h80);
        cmd(3'h2, 0);
        `CHK(seen, 1'b0)
        rc(4'h2, 8'h04);
        cmd(3'h5, 0);
        `CHK(r.kind, OP_CHIP)
        `CHK(r.keepEeprom, 1'b1)
        targetAppCode <= 1'b0;
        sectionMismatch <= 1'b1;
        cmd(3'h1, 0);
        `CHK(seen, 1'b0)
        rc(4'h2, 8'h04);
        sectionMismatch <= 1'b0;
        execInBoot <= 1'b1;
        lock(8'h02);
        #1 `CHK(bootBlank, 1'b0)
        execInBoot <= 1'b0;
        rc(4'h1, 8'h03);
        #1 `CHK(bootBlank, 1'b1)
        fin("protection");
        wr(4'h3, 8'h01);
        rc(4'h4, 8'h01);
        `CHK(irq, 1'b1)
        wr(4'h9, 8'h00);
        slow <= 1'b1;
        cmd(3'h1, 0);
        sleepReq <= 1'b1;
        wr(4'h4, 8'h01);
        #1 `CHK(irq, 1'b0)
        `CHK(clockHold, 1'b1)
        `CHK(ctrlSleep, 1'b0)
        waitIdle();
        `CHK(irq, 1'b1)
        `CHK(ctrlSleep, 1'b1)
        sleepIdle <= 1'b1;
        @(posedge clk);
        #1 `CHK(wakeReq, 1'b1)
        sleepReq <= 1'b0;
        sleepIdle <= 1'b0;
        wakeUp <= 1'b1;
        @(posedge clk);
        wakeUp <= 1'b0;
        waitFor(1'b1, 4);
        `CHK(seen, 1'b1)
        fin("sleep");
        cmd(3'h1, 0);
        rstn <= 1'b0;
        #1 `CHK(arrayAbort, 1'b1)
        rst(3'b111);
        fin("abort");
        printVerdict();
    end
endmodule : nvc_ctrl_tb_top

`default_nettype wire
